// File: src/dsq_pkg.sv
// Constants for one scatter-gather DMA channel: register map, descriptor and status layout.
// Assumes an AXI4-Lite register bus and same-clock descriptor, mover and status-write engines.
// Summary of operation
// - Source descriptor: address 63..0, count 87..64, flags 95..88, handle, identifier.
// - Descriptor byte count zero means a transfer of 2^24 bytes.
// - Source flags 7..4 feed AXI read cache; bits 6..4 feed PCIe attributes.
// - Source interrupt flag with packet end raises an event after status write.
// - Source packet-end flag causes completion status when that packet end lands.
// - Flag bit 0 selects AXI (1) or PCIe (0) for source and destination.
// - Packet-end source handle and identifier go into source completion status.
// - Destination descriptor: address, count, flags, handle; top bits and flags 3..2 reserved.
// - Destination flags 7..4 are write attributes, AXI cache or PCIe bits.
// - Destination flag bit 1 drops the element remainder at packet end.
// - Final destination descriptor handle goes into destination completion status.
// - Status elements are 32 or 64 bits, selected by a channel register.
// - Wide status: identifier in 63..48, handle in 47..32.
// - Status bit 31 marks nonzero upper half; zero in narrow status.
// - Status bits 30..4 hold the byte count, saturating at 2^27-1.
// - Status bits: 3 internal, 2 destination, 1 source error, 0 done.
// - Channel merges source and destination lists, splitting at either boundary.
// - The channel has its own queue and control/status register set.
// - A descriptor is fetched only once the limit has moved past it.
// - The element at the limit index is never executed or written.
// - Queue of size N uses indices 0..N-1 and wraps to 0.
// - Element address is base plus index times element size.
package dsq_pkg;
  // Register byte offsets, queue region and field word indices
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STAT_OFS = 12'h004;
  localparam logic [4:0] QREG_REGION = 5'h02;
  localparam logic [2:0] QF_BASE_LO = 3'h0;
  localparam logic [2:0] QF_BASE_HI = 3'h1;
  localparam logic [2:0] QF_LENGTH = 3'h2;
  localparam logic [2:0] QF_NEXT = 3'h3;
  localparam logic [2:0] QF_LIMIT = 3'h4;
  // Queue numbers
  localparam int Q_SRC = 0;
  localparam int Q_DST = 1;
  localparam int Q_SOURCE_COMPLETION_QUEUE = 2;
  localparam int Q_DEST_COMPLETION_QUEUE = 3;
  // Control bits
  localparam int CTRL_EN = 0;
  localparam int CTRL_WIDE = 1;
  localparam int CTRL_IRQ_PCIE = 2;
  localparam int CTRL_IRQ_AXI = 3;
  // Descriptor fields
  localparam int D_CNT_LSB = 64;
  localparam int D_FLG_LSB = 88;
  localparam int D_HDL_LSB = 96;
  localparam int D_UID_LSB = 112;
  localparam int F_LOC = 0;
  localparam int F_EOP = 1;
  localparam int F_IRQ = 2;
  localparam int F_ATTR_LSB = 4;
  localparam logic [24:0] FULL_CNT = 25'h100_0000;
  localparam logic [26:0] CNT_MAX = 27'h7FF_FFFF;
  // Element sizes as index shifts
  localparam int DESC_SHIFT = 4;
  localparam int STAT_SHIFT_N = 2;
  localparam int STAT_SHIFT_W = 3;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_FSRC = 3'b001,
    S_FDST = 3'b010,
    S_MOVE = 3'b011,
    S_SOURCE_COMPLETION_QUEUE = 3'b100,
    S_DEST_COMPLETION_QUEUE = 3'b101
  } dsq_state_e;
endpackage

// File: src/dsq_channel.sv
// One scatter-gather DMA channel: register set, descriptor fetch, transfer split, status write.
// Assumes fetch, mover and status-write engines on the same clock with request/ack handshakes.
module dsq_channel (
  // Clock and reset
  input logic clock,
  input logic rstn,
  // AXI4-Lite register slave
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [11:0] s_axi_awaddr,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  input logic [11:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Descriptor fetch
  output logic fetch_req,
  output logic [63:0] fetch_addr,
  input logic fetch_ack,
  input logic [127:0] fetch_data,
  input logic fetch_err,
  // Data mover
  output logic move_req,
  output logic [63:0] move_src_addr,
  output logic [63:0] move_dst_addr,
  output logic [24:0] move_len,
  output logic move_src_axi,
  output logic move_dst_axi,
  output logic [3:0] manager_read_cache_attr,
  output logic [2:0] move_rd_pcie_attr,
  output logic [3:0] move_wr_cache_attr,
  output logic [2:0] move_wr_pcie_attr,
  input logic move_done,
  input logic move_src_err,
  input logic move_dst_err,
  // Status write
  output logic stat_req,
  output logic [63:0] stat_addr,
  output logic [63:0] stat_data,
  output logic stat_wide,
  input logic stat_ack,
  // Interrupt events
  output logic irq_pcie_event,
  output logic irq_axi_event
);
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic aw_ok_r, w_ok_r;
  logic [11:0] aw_addr_r;
  logic [31:0] w_data_r, rdata_r;
  logic [3:0] w_strb_r;
  logic [1:0] bresp_r, rresp_r;
  logic [3:0] ctrl_r;
  logic [63:0] qbase_r [4];
  logic [15:0] qlen_r [4];
  logic [15:0] qnext_r [4];
  logic [15:0] qlim_r [4];
  logic [3:0] qadv;
  logic [3:0] qavail;
  logic do_wr, wr_map, rd_map;
  logic [31:0] rd_val;
  dsq_pkg::dsq_state_e state_r;
  logic pend_r;
  logic [63:0] src_addr_r, dst_addr_r;
  logic [24:0] src_rem_r, dst_rem_r;
  logic [7:0] src_flg_r, dst_flg_r;
  logic [15:0] src_hdl_r, src_uid_r, dst_hdl_r;
  logic [26:0] pkt_cnt_r;
  logic [2:0] pkt_err_r;
  logic fetch_req_r, move_req_r, stat_req_r, stat_wide_r;
  logic [63:0] fetch_addr_r, mv_src_r, mv_dst_r, stat_addr_r, stat_data_r;
  logic [24:0] mv_len_r;
  logic mv_src_axi_r, mv_dst_axi_r;
  logic [3:0] rd_cache_r, wr_cache_r;
  logic [2:0] rd_pattr_r, wr_pattr_r;
  logic irq_pcie_r, irq_axi_r;
  logic [24:0] chunk;
  logic [27:0] cnt_sum;
  logic [24:0] dcnt;
  logic [31:0] st_lo;
  logic [31:0] st_hi;
  int st_shift;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        res[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [63:0] elem_addr(input logic [63:0] base, input logic [15:0] idx,
                                            input int shift);
    elem_addr = base + (64'(idx) << shift);
  endfunction

  // Register bus write side
  assign do_wr = aw_ok_r && w_ok_r && !bvalid_r;
  assign wr_map = (aw_addr_r == dsq_pkg::CTRL_OFS) || (aw_addr_r == dsq_pkg::STAT_OFS) ||
                  ((aw_addr_r[11:7] == dsq_pkg::QREG_REGION) && (aw_addr_r[4:2] <= 3'h4));

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      aw_ok_r <= 1'b0;
      w_ok_r <= 1'b0;
      aw_addr_r <= 12'h000;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= dsq_pkg::RESP_OK;
    end
    else
    begin
      if (s_axi_awvalid && awready_r)
      begin
        aw_ok_r <= 1'b1;
        aw_addr_r <= {s_axi_awaddr[11:2], 2'b00};
        awready_r <= 1'b0;
      end
      if (s_axi_wvalid && wready_r)
      begin
        w_ok_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        wready_r <= 1'b0;
      end
      if (do_wr)
      begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_map ? dsq_pkg::RESP_OK : dsq_pkg::RESP_ERR;
      end
      if (bvalid_r && s_axi_bready)
      begin
        bvalid_r <= 1'b0;
        aw_ok_r <= 1'b0;
        w_ok_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  // Channel control register
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_r <= 4'h0;
    end
    else if (do_wr && aw_addr_r == dsq_pkg::CTRL_OFS)
    begin
      ctrl_r <= 4'(merge({28'h000_0000, ctrl_r}, w_data_r, w_strb_r));
    end
  end

  // Per-queue registers; layout fields lock while enabled
  for (genvar q = 0; q < 4; q++)
  begin : g_q
    logic hit;
    logic [15:0] nxt_inc;
    assign hit = do_wr && aw_addr_r[11:7] == dsq_pkg::QREG_REGION && aw_addr_r[6:5] == 2'(q);
    assign nxt_inc = (qnext_r[q] == qlen_r[q] - 16'h0001) ? 16'h0000
                     : qnext_r[q] + 16'h0001;
    assign qavail[q] = qnext_r[q] != qlim_r[q];
    always_ff @(posedge clock or negedge rstn)
    begin
      if (!rstn)
      begin
        qbase_r[q] <= 64'h0000_0000_0000_0000;
        qlen_r[q] <= 16'h0000;
        qnext_r[q] <= 16'h0000;
        qlim_r[q] <= 16'h0000;
      end
      else
      begin
        if (hit && aw_addr_r[4:2] == dsq_pkg::QF_LIMIT)
        begin
          qlim_r[q] <= 16'(merge({16'h0000, qlim_r[q]}, w_data_r, w_strb_r));
        end
        if (hit && !ctrl_r[dsq_pkg::CTRL_EN])
        begin
          case (aw_addr_r[4:2])
            dsq_pkg::QF_BASE_LO: qbase_r[q][31:0] <= merge(qbase_r[q][31:0], w_data_r, w_strb_r);
            dsq_pkg::QF_BASE_HI: qbase_r[q][63:32] <= merge(qbase_r[q][63:32], w_data_r, w_strb_r);
            dsq_pkg::QF_LENGTH: qlen_r[q] <= 16'(merge({16'h0000, qlen_r[q]}, w_data_r, w_strb_r));
            dsq_pkg::QF_NEXT: qnext_r[q] <= 16'(merge({16'h0000, qnext_r[q]}, w_data_r, w_strb_r));
            default: ;
          endcase
        end
        else if (qadv[q])
        begin
          qnext_r[q] <= nxt_inc;
        end
      end
    end
  end

  // Register bus read side
  always_comb
  begin
    rd_val = 32'h0000_0000;
    rd_map = 1'b1;
    if (s_axi_araddr[11:2] == dsq_pkg::CTRL_OFS[11:2])
    begin
      rd_val = {28'h000_0000, ctrl_r};
    end
    else if (s_axi_araddr[11:2] == dsq_pkg::STAT_OFS[11:2])
    begin
      rd_val = {28'h000_0000, state_r,
                ctrl_r[dsq_pkg::CTRL_EN] || state_r != dsq_pkg::S_IDLE};
    end
    else if (s_axi_araddr[11:7] == dsq_pkg::QREG_REGION)
    begin
      case (s_axi_araddr[4:2])
        dsq_pkg::QF_BASE_LO: rd_val = qbase_r[s_axi_araddr[6:5]][31:0];
        dsq_pkg::QF_BASE_HI: rd_val = qbase_r[s_axi_araddr[6:5]][63:32];
        dsq_pkg::QF_LENGTH: rd_val = {16'h0000, qlen_r[s_axi_araddr[6:5]]};
        dsq_pkg::QF_NEXT: rd_val = {16'h0000, qnext_r[s_axi_araddr[6:5]]};
        dsq_pkg::QF_LIMIT: rd_val = {16'h0000, qlim_r[s_axi_araddr[6:5]]};
        default: rd_map = 1'b0;
      endcase
    end
    else
    begin
      rd_map = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= dsq_pkg::RESP_OK;
    end
    else if (s_axi_arvalid && arready_r)
    begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rd_val;
      rresp_r <= rd_map ? dsq_pkg::RESP_OK : dsq_pkg::RESP_ERR;
    end
    else if (rvalid_r && s_axi_rready)
    begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // Engine helpers
  assign chunk = (src_rem_r < dst_rem_r) ? src_rem_r : dst_rem_r;
  assign cnt_sum = {1'b0, pkt_cnt_r} + 28'(mv_len_r);
  assign dcnt = (fetch_data[87:64] == 24'h00_0000) ? dsq_pkg::FULL_CNT
                : {1'b0, fetch_data[87:64]};
  assign st_hi = {src_uid_r,
                  (state_r == dsq_pkg::S_DEST_COMPLETION_QUEUE) ? dst_hdl_r : src_hdl_r};
  assign st_lo = {ctrl_r[dsq_pkg::CTRL_WIDE] && st_hi != 32'h0000_0000, pkt_cnt_r,
                  pkt_err_r, 1'b1};
  assign qadv[dsq_pkg::Q_SRC] = state_r == dsq_pkg::S_FSRC && fetch_ack;
  assign qadv[dsq_pkg::Q_DST] = state_r == dsq_pkg::S_FDST && fetch_ack;
  assign qadv[dsq_pkg::Q_SOURCE_COMPLETION_QUEUE] = state_r == dsq_pkg::S_SOURCE_COMPLETION_QUEUE && stat_ack;
  assign qadv[dsq_pkg::Q_DEST_COMPLETION_QUEUE] = state_r == dsq_pkg::S_DEST_COMPLETION_QUEUE && stat_ack;
  assign st_shift = ctrl_r[dsq_pkg::CTRL_WIDE] ? dsq_pkg::STAT_SHIFT_W : dsq_pkg::STAT_SHIFT_N;

  // Channel sequencer
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r <= dsq_pkg::S_IDLE;
      pend_r <= 1'b0;
      src_addr_r <= 64'h0000_0000_0000_0000;
      dst_addr_r <= 64'h0000_0000_0000_0000;
      src_rem_r <= 25'h000_0000;
      dst_rem_r <= 25'h000_0000;
      src_flg_r <= 8'h00;
      dst_flg_r <= 8'h00;
      src_hdl_r <= 16'h0000;
      src_uid_r <= 16'h0000;
      dst_hdl_r <= 16'h0000;
      pkt_cnt_r <= 27'h000_0000;
      pkt_err_r <= 3'h0;
      fetch_req_r <= 1'b0;
      fetch_addr_r <= 64'h0000_0000_0000_0000;
      move_req_r <= 1'b0;
      mv_src_r <= 64'h0000_0000_0000_0000;
      mv_dst_r <= 64'h0000_0000_0000_0000;
      mv_len_r <= 25'h000_0000;
      mv_src_axi_r <= 1'b0;
      mv_dst_axi_r <= 1'b0;
      rd_cache_r <= 4'h0;
      wr_cache_r <= 4'h0;
      rd_pattr_r <= 3'h0;
      wr_pattr_r <= 3'h0;
      stat_req_r <= 1'b0;
      stat_addr_r <= 64'h0000_0000_0000_0000;
      stat_data_r <= 64'h0000_0000_0000_0000;
      stat_wide_r <= 1'b0;
      irq_pcie_r <= 1'b0;
      irq_axi_r <= 1'b0;
    end
    else
    begin
      irq_pcie_r <= 1'b0;
      irq_axi_r <= 1'b0;
      case (state_r)
        dsq_pkg::S_IDLE:
        begin
          if (ctrl_r[dsq_pkg::CTRL_EN])
          begin
            if (src_rem_r == 25'h000_0000 && qavail[dsq_pkg::Q_SRC])
            begin
              state_r <= dsq_pkg::S_FSRC;
              fetch_req_r <= 1'b1;
              fetch_addr_r <= elem_addr(qbase_r[dsq_pkg::Q_SRC], qnext_r[dsq_pkg::Q_SRC],
                                        dsq_pkg::DESC_SHIFT);
            end
            else if (dst_rem_r == 25'h000_0000 && qavail[dsq_pkg::Q_DST])
            begin
              state_r <= dsq_pkg::S_FDST;
              fetch_req_r <= 1'b1;
              fetch_addr_r <= elem_addr(qbase_r[dsq_pkg::Q_DST], qnext_r[dsq_pkg::Q_DST],
                                        dsq_pkg::DESC_SHIFT);
            end
            else if (src_rem_r != 25'h000_0000 && dst_rem_r != 25'h000_0000)
            begin
              state_r <= dsq_pkg::S_MOVE;
              move_req_r <= 1'b1;
              mv_src_r <= src_addr_r;
              mv_dst_r <= dst_addr_r;
              mv_len_r <= chunk;
              mv_src_axi_r <= src_flg_r[dsq_pkg::F_LOC];
              mv_dst_axi_r <= dst_flg_r[dsq_pkg::F_LOC];
              rd_cache_r <= src_flg_r[dsq_pkg::F_LOC] ? src_flg_r[7:4] : 4'h0;
              rd_pattr_r <= src_flg_r[dsq_pkg::F_LOC] ? 3'h0 : src_flg_r[6:4];
              wr_cache_r <= dst_flg_r[dsq_pkg::F_LOC] ? dst_flg_r[7:4] : 4'h0;
              wr_pattr_r <= dst_flg_r[dsq_pkg::F_LOC] ? 3'h0 : dst_flg_r[6:4];
            end
          end
        end
        dsq_pkg::S_FSRC:
        begin
          if (fetch_ack)
          begin
            fetch_req_r <= 1'b0;
            state_r <= dsq_pkg::S_IDLE;
            src_addr_r <= fetch_data[63:0];
            src_rem_r <= dcnt;
            src_flg_r <= fetch_data[dsq_pkg::D_FLG_LSB +: 8];
            src_hdl_r <= fetch_data[dsq_pkg::D_HDL_LSB +: 16];
            src_uid_r <= fetch_data[dsq_pkg::D_UID_LSB +: 16];
            if (fetch_err)
            begin
              pkt_err_r[2] <= 1'b1;
            end
          end
        end
        dsq_pkg::S_FDST:
        begin
          if (fetch_ack)
          begin
            fetch_req_r <= 1'b0;
            state_r <= dsq_pkg::S_IDLE;
            dst_addr_r <= fetch_data[63:0];
            dst_rem_r <= dcnt;
            dst_flg_r <= {fetch_data[95:92], 2'b00, fetch_data[89:88]};
            dst_hdl_r <= fetch_data[dsq_pkg::D_HDL_LSB +: 16];
            if (fetch_err)
            begin
              pkt_err_r[2] <= 1'b1;
            end
          end
        end
        dsq_pkg::S_MOVE:
        begin
          if (move_done)
          begin
            move_req_r <= 1'b0;
            src_rem_r <= src_rem_r - mv_len_r;
            dst_rem_r <= dst_rem_r - mv_len_r;
            src_addr_r <= src_addr_r + 64'(mv_len_r);
            dst_addr_r <= dst_addr_r + 64'(mv_len_r);
            pkt_cnt_r <= cnt_sum[27] ? dsq_pkg::CNT_MAX : cnt_sum[26:0];
            pkt_err_r[1:0] <= pkt_err_r[1:0] | {move_dst_err, move_src_err};
            if (src_rem_r == mv_len_r && src_flg_r[dsq_pkg::F_EOP])
            begin
              state_r <= dsq_pkg::S_SOURCE_COMPLETION_QUEUE;
            end
            else
            begin
              state_r <= dsq_pkg::S_IDLE;
            end
          end
        end
        dsq_pkg::S_SOURCE_COMPLETION_QUEUE, dsq_pkg::S_DEST_COMPLETION_QUEUE:
        begin
          if (!pend_r && qavail[(state_r == dsq_pkg::S_SOURCE_COMPLETION_QUEUE) ? dsq_pkg::Q_SOURCE_COMPLETION_QUEUE
                                : dsq_pkg::Q_DEST_COMPLETION_QUEUE])
          begin
            pend_r <= 1'b1;
            stat_req_r <= 1'b1;
            stat_wide_r <= ctrl_r[dsq_pkg::CTRL_WIDE];
            stat_data_r <= {ctrl_r[dsq_pkg::CTRL_WIDE] ? st_hi : 32'h0000_0000, st_lo};
            stat_addr_r <= (state_r == dsq_pkg::S_SOURCE_COMPLETION_QUEUE)
              ? elem_addr(qbase_r[dsq_pkg::Q_SOURCE_COMPLETION_QUEUE], qnext_r[dsq_pkg::Q_SOURCE_COMPLETION_QUEUE], st_shift)
              : elem_addr(qbase_r[dsq_pkg::Q_DEST_COMPLETION_QUEUE], qnext_r[dsq_pkg::Q_DEST_COMPLETION_QUEUE], st_shift);
          end
          else if (pend_r && stat_ack)
          begin
            pend_r <= 1'b0;
            stat_req_r <= 1'b0;
            if (state_r == dsq_pkg::S_SOURCE_COMPLETION_QUEUE)
            begin
              state_r <= dsq_pkg::S_DEST_COMPLETION_QUEUE;
            end
            else
            begin
              state_r <= dsq_pkg::S_IDLE;
              pkt_cnt_r <= 27'h000_0000;
              pkt_err_r <= 3'h0;
              irq_pcie_r <= src_flg_r[dsq_pkg::F_IRQ] && ctrl_r[dsq_pkg::CTRL_IRQ_PCIE];
              irq_axi_r <= src_flg_r[dsq_pkg::F_IRQ] && ctrl_r[dsq_pkg::CTRL_IRQ_AXI];
              if (dst_flg_r[dsq_pkg::F_EOP])
              begin
                dst_rem_r <= 25'h000_0000;
              end
            end
          end
        end
        default:
        begin
          state_r <= dsq_pkg::S_IDLE;
        end
      endcase
    end
  end

  // Outputs
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign fetch_req = fetch_req_r;
  assign fetch_addr = fetch_addr_r;
  assign move_req = move_req_r;
  assign move_src_addr = mv_src_r;
  assign move_dst_addr = mv_dst_r;
  assign move_len = mv_len_r;
  assign move_src_axi = mv_src_axi_r;
  assign move_dst_axi = mv_dst_axi_r;
  assign manager_read_cache_attr = rd_cache_r;
  assign move_rd_pcie_attr = rd_pattr_r;
  assign move_wr_cache_attr = wr_cache_r;
  assign move_wr_pcie_attr = wr_pattr_r;
  assign stat_req = stat_req_r;
  assign stat_addr = stat_addr_r;
  assign stat_data = stat_data_r;
  assign stat_wide = stat_wide_r;
  assign irq_pcie_event = irq_pcie_r;
  assign irq_axi_event = irq_axi_r;
endmodule

// File: sim/dsq_channel_properties.sv
// Checks on the channel's engine request and status ports.
// Bound to dsq_channel; one clock, async active-low reset.
module dsq_channel_properties (
  // Clock and reset
  input logic clock,
  input logic rstn,
  // Engine ports
  input logic fetch_req,
  input logic [63:0] fetch_addr,
  input logic fetch_ack,
  input logic move_req,
  input logic [24:0] move_len,
  input logic move_done,
  input logic move_src_axi,
  input logic [3:0] manager_read_cache_attr,
  input logic [2:0] move_rd_pcie_attr,
  input logic stat_req,
  input logic [63:0] stat_data,
  input logic stat_wide,
  input logic irq_pcie_event
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  a_fetch_hold:
    assert property (fetch_req && !fetch_ack |=> fetch_req && $stable(fetch_addr))
    else $error("fetch dropped");
  a_move_hold:
    assert property (move_req && !move_done |=> move_req && $stable(move_len))
    else $error("move dropped");
  a_len_range:
    assert property (move_req |-> move_len != 25'h0 && move_len <= 25'h100_0000)
    else $error("bad length");
  a_read_attr:
    assert property (move_req |->
      (move_src_axi ? {1'b0, move_rd_pcie_attr} : manager_read_cache_attr) == 4'h0)
    else $error("bad read attr");
  a_upper_flag:
    assert property (stat_req |-> stat_data[31] == (stat_wide && stat_data[63:32] != 32'h0))
    else $error("bad upper flag");
  a_narrow_zero:
    assert property (stat_req && !stat_wide |-> stat_data[63:32] == 32'h0)
    else $error("narrow upper set");
  a_status_done:
    assert property (stat_req |-> stat_data[0])
    else $error("done bit clear");
  a_irq_pulse:
    assert property (irq_pcie_event |=> !irq_pcie_event)
    else $error("irq too long");
  c_wide: cover property (stat_req && stat_wide);
  c_full: cover property (move_req && move_len == 25'h100_0000);
  c_irq: cover property (irq_pcie_event);
endmodule

bind dsq_channel dsq_channel_properties u_props (.*);

// File: sim/dsq_far_model.sv
// Far side: descriptor memory, data mover and status sink.
// Answers each request after 1 or 5 cycles, alternating.
module dsq_far_model (
  // Clock and reset
  input logic clock,
  input logic rstn,
  // Requests
  input logic fetch_req,
  input logic [63:0] fetch_addr,
  input logic move_req,
  input logic stat_req,
  input logic inject_err,
  // Answers
  output logic fetch_ack,
  output logic [127:0] fetch_data,
  output logic fetch_err,
  output logic move_done,
  output logic move_src_err,
  output logic move_dst_err,
  output logic stat_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [127:0] mem [logic [63:0]];
  logic ack_r;
  logic slow_r;
  logic [2:0] cnt_r;
  assign fetch_ack = ack_r & fetch_req;
  assign move_done = ack_r & move_req;
  assign stat_ack = ack_r & stat_req;
  assign fetch_data = fetch_ack ? mem[fetch_addr] : {32{cnt_r[0], 3'h5}};
  assign fetch_err = 1'b0;
  assign move_dst_err = 1'b0;
  assign move_src_err = move_done & inject_err;
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      ack_r <= 1'b0;
      slow_r <= 1'b0;
      cnt_r <= 3'h0;
    end
    else if (ack_r)
    begin
      ack_r <= 1'b0;
      slow_r <= ~slow_r;
      cnt_r <= slow_r ? 3'h0 : 3'h4;
    end
    else if (fetch_req | move_req | stat_req)
    begin
      ack_r <= cnt_r == 3'h0;
      cnt_r <= cnt_r - 3'(cnt_r != 3'h0);
    end
  end
endmodule

// File: sim/testbench.sv
// Bench: registers over AXI4-Lite, then two packets over split fragments.
// Assumes dsq_far_model as the far side of the engine ports.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0, rstn = 1'b0, inject_err = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d, seed = 32'h0001_3F4A;
  logic [3:0] s_axi_wstrb = 4'hF, manager_read_cache_attr, move_wr_cache_attr;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, fetch_req;
  logic fetch_ack, fetch_err, move_req, move_done, move_src_err, move_dst_err, move_src_axi;
  logic move_dst_axi, stat_req, stat_wide, stat_ack, irq_pcie_event, irq_axi_event;
  logic [63:0] fetch_addr, move_src_addr, move_dst_addr, stat_addr, stat_data;
  logic [127:0] fetch_data, exp_f [$], exp_m [$], exp_s [$];
  logic [24:0] move_len;
  logic [23:0] ca;
  logic [2:0] move_rd_pcie_attr, move_wr_pcie_attr;
  logic [15:0] rv [6];
  int fails = 0, cmp_count = 0, cycles = 0, n_pcie = 0, n_axi = 0;
  dsq_channel DUT (.*);
  dsq_far_model FAR (.*);
  always #10 clock = ~clock;
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [127:0] mv(logic [31:0] s, logic [31:0] t, logic [24:0] n,
    logic [15:0] a);
    return {23'h0, s, t, n, a};
  endfunction
  function automatic logic [127:0] st(logic w, logic [62:0] a, logic [15:0] u, logic [15:0] h,
    logic [26:0] n, logic [2:0] e);
    return {w, a, u, h, |{u, h}, n, e, 1'b1};
  endfunction
  task automatic chk(string n, logic [127:0] g, logic [127:0] e);
    cmp_count++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bready && s_axi_bvalid)
      begin
        s_axi_bready <= 1'b0;
        r = s_axi_bresp;
      end
    end
    while (s_axi_bready);
  endtask
  task automatic rd(logic [11:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rready && s_axi_rvalid)
      begin
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        r = s_axi_rresp;
      end
    end
    while (s_axi_rready);
  endtask
  task end_sim;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cycles++;
    if (fetch_req && fetch_ack) chk("fetch", {64'h0, fetch_addr}, exp_f.pop_front());
    if (move_req && move_done) chk("move", mv(move_src_addr[31:0], move_dst_addr[31:0],
      move_len, {manager_read_cache_attr, move_rd_pcie_attr, move_wr_cache_attr,
      move_wr_pcie_attr, move_src_axi, move_dst_axi}), exp_m.pop_front());
    if (stat_req && stat_ack) chk("status", {stat_wide, stat_addr[62:0], stat_data},
      exp_s.pop_front());
    if (irq_pcie_event) n_pcie++;
    if (irq_axi_event) n_axi++;
    if (cycles == 3000)
    begin
      fails++;
      end_sim;
    end
  end
  initial
  begin
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    rd(12'h004);
    chk("running", 128'(d), 128'h0);
    rd(12'hFFC);
    chk("unmapped", 128'(r), 128'h2);
    for (int q = 0; q < 4; q++)
    begin
      wr(12'h100 + 12'(q * 32), 32'(q + 1) << 12);
      wr(12'h108 + 12'(q * 32), 32'(q < 2 ? 2 : 4));
      wr(12'h110 + 12'(q * 32), 32'(q < 2 ? 0 : 3));
    end
    foreach (rv[i])
    begin
      seed = lfsr(seed);
      rv[i] = seed[15:0];
    end
    ca = {8'h0, seed[31:16] | 16'h1};
    FAR.mem[64'h1000] = {rv[0], rv[1], 8'h37, ca, 64'h8000_0000};
    FAR.mem[64'h2000] = {16'h0, rv[2], 8'h91, ca + 24'h10, 64'hA000_0000};
    FAR.mem[64'h1010] = {rv[3], rv[4], 8'h52, 24'h0, 64'h9000_0000};
    FAR.mem[64'h2010] = {16'h0, rv[5], 8'h60, 24'h0, 64'hB000_0000};
    for (int i = 0; i < 4; i++) FAR.mem[64'(i % 2 * 4096 + i / 2 * 8 + 'h3000)] = 128'h0;
    exp_f = '{128'h1000, 128'h2000, 128'h1010, 128'h2010};
    exp_m = '{mv(32'h8000_0000, 32'hA000_0000, 25'(ca), 16'h3123),
      mv(32'h9000_0000, 32'hA000_0000 + 32'(ca), 25'h10, 16'h0B21),
      mv(32'h9000_0010, 32'hB000_0000, 25'hFF_FFF0, 16'h0A18)};
    exp_s = '{st(1'b1, 63'h3000, rv[0], rv[1], 27'(ca), 3'h0),
      st(1'b1, 63'h4000, rv[0], rv[2], 27'(ca), 3'h0),
      st(1'b0, 63'h3004, 16'h0, 16'h0, 27'h100_0000, 3'h1),
      st(1'b0, 63'h4004, 16'h0, 16'h0, 27'h100_0000, 3'h1)};
    wr(12'h000, 32'hF);
    wr(12'h100, 32'h5000);
    chk("locked resp", 128'(r), 128'h0);
    rd(12'h100);
    chk("locked base", 128'(d), 128'h1000);
    repeat (10) @(posedge clock);
    wr(12'h110, 32'h1);
    wr(12'h130, 32'h1);
    while (exp_s.size() > 2) @(posedge clock);
    wr(12'h000, 32'hD);
    inject_err <= 1'b1;
    wr(12'h110, 32'h0);
    wr(12'h130, 32'h0);
    while (exp_s.size() > 0) @(posedge clock);
    repeat (20) @(posedge clock);
    wr(12'h000, 32'h0);
    rd(12'h004);
    chk("running off", 128'(d[0]), 128'h0);
    chk("irq count", 128'({n_pcie, n_axi}), {64'h0, 32'h1, 32'h1});
    end_sim;
  end
endmodule
